// ---- logic/spf_pkg.sv ----
// Package for the shared pin function selector: register map and widths
package spf_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] GPIO_EN_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] GPIO_DIR_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] GPIO_OUT_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] GPIO_IN_OFS = 8'h0c;
	localparam logic [ADDR_W-1:0] PIN_STAT_OFS = 8'h10;
	localparam int unsigned GPIO_W = 16;
	localparam int unsigned GPIO_UP_LO = 9;
	localparam int unsigned GPIO_UP_HI = 15;
	localparam int unsigned GPIO1_BIT = 1;
	localparam int unsigned GPIO2_BIT = 2;
	localparam int unsigned HOST_W = 32;
	localparam int unsigned PCI_CTL_W = 11;
	localparam int unsigned PCI_ONLY_W = 5;
	localparam int unsigned QUARTER_DIV = 4;
	localparam int unsigned SIXTH_DIV = 6;
	localparam logic [GPIO_W-1:0] GPIO_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [HOST_W-1:0] data;
		logic [PCI_CTL_W-1:0] ctl;
	} spf_shared_t;

	typedef struct packed {
		logic [HOST_W-1:0] o;
		logic [HOST_W-1:0] oe;
	} spf_drive_t;
endpackage

// ---- logic/spf_pin_mux.sv ----
// Shared pin function selector with AXI4-Lite access to GPIO control
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module spf_pin_mux
	import spf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pci_strap,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [GPIO_W-1:0] gpio_pad_i,
	output logic [GPIO_W-1:0] gpio_pad_o,
	output logic [GPIO_W-1:0] gpio_pad_oe,
	input wire spf_drive_t host_port_drive,
	input wire spf_drive_t pci_ad_drive,
	input wire logic [HOST_W-1:0] host_port_data_pins_i,
	output logic [HOST_W-1:0] host_port_data_pins_o,
	output logic [HOST_W-1:0] host_port_data_pins_oe,
	input wire logic [GPIO_UP_HI:GPIO_UP_LO] pci_upper_o,
	input wire logic [GPIO_UP_HI:GPIO_UP_LO] pci_upper_oe,
	output logic [GPIO_UP_HI:GPIO_UP_LO] pci_upper_i,
	input wire logic [PCI_ONLY_W-1:0] pci_only_o,
	input wire logic [PCI_ONLY_W-1:0] pci_only_oe,
	output logic [PCI_ONLY_W-1:0] pci_only_pad_o,
	output logic [PCI_ONLY_W-1:0] pci_only_pad_oe,
	output logic [HOST_W-1:0] host_port_data_in,
	output logic [HOST_W-1:0] pci_ad_in,
	output logic pci_enabled,
	output logic host_port_enabled
);
	// Synchronisers for pad inputs
	logic strap_m_q, strap_s_q;
	logic [GPIO_W-1:0] gin_m_q, gin_s_q;
	logic [HOST_W-1:0] hd_m_q, hd_s_q;
	always_ff @(posedge clk) begin
		strap_m_q <= pci_strap;
		strap_s_q <= strap_m_q;
		gin_m_q <= gpio_pad_i;
		gin_s_q <= gin_m_q;
		hd_m_q <= host_port_data_pins_i;
		hd_s_q <= hd_m_q;
	end

	// Strap latch, transparent only during reset
	logic pci_sel_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pci_sel_q <= strap_s_q;
		end
	end

	// Software registers
	logic [GPIO_W-1:0] gpio_en_q, gpio_dir_q, gpio_out_q;
	logic aw_got_q, w_got_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [DATA_W-1:0] w_data_q;
	logic [3:0] w_strb_q;
	wire logic wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	wire logic [GPIO_W-1:0] wmask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	wire logic wr_en = wr_go && aw_addr_q == GPIO_EN_OFS;
	wire logic wr_dir = wr_go && aw_addr_q == GPIO_DIR_OFS;
	wire logic wr_out = wr_go && aw_addr_q == GPIO_OUT_OFS;
	wire logic wr_ok = wr_en || wr_dir || wr_out;

	function automatic logic [GPIO_W-1:0] merge(
		input logic [GPIO_W-1:0] old,
		input logic [GPIO_W-1:0] nw,
		input logic [GPIO_W-1:0] m
	);
		merge = (old & ~m) | (nw & m);
	endfunction

	wire logic [GPIO_W-1:0] w_low = w_data_q[GPIO_W-1:0];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_got_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_got_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_en_q <= GPIO_RST;
			gpio_dir_q <= GPIO_RST;
			gpio_out_q <= GPIO_RST;
		end else begin
			if (wr_en) begin
				gpio_en_q <= merge(gpio_en_q, w_low, wmask);
			end
			if (wr_dir) begin
				gpio_dir_q <= merge(gpio_dir_q, w_low, wmask);
			end
			if (wr_out) begin
				gpio_out_q <= merge(gpio_out_q, w_low, wmask);
			end
		end
	end

	// Write handshake outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Clock dividers
	localparam int unsigned QW = $clog2(QUARTER_DIV);
	localparam int unsigned SW = $clog2(SIXTH_DIV);
	logic [QW-1:0] qcnt_q;
	logic [SW-1:0] scnt_q;
	logic qclk_q, sclk_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			qcnt_q <= '0;
			scnt_q <= '0;
			qclk_q <= 1'b0;
			sclk_q <= 1'b0;
		end else begin
			qcnt_q <= qcnt_q + 1'b1;
			if (qcnt_q == QW'(QUARTER_DIV / 2 - 1)) begin
				qclk_q <= ~qclk_q;
			end
			if (qcnt_q == QW'(QUARTER_DIV - 1)) begin
				qclk_q <= ~qclk_q;
			end
			if (scnt_q == SW'(SIXTH_DIV - 1)) begin
				scnt_q <= '0;
			end else begin
				scnt_q <= scnt_q + 1'b1;
			end
			if (scnt_q == SW'(SIXTH_DIV / 2 - 1) ||
				scnt_q == SW'(SIXTH_DIV - 1)) begin
				sclk_q <= ~sclk_q;
			end
		end
	end

	// GPIO availability: upper pins belong to PCI when selected
	logic [GPIO_W-1:0] avail;
	always_comb begin
		avail = {GPIO_W{1'b1}};
		avail[0] = 1'b0;
		for (int i = 3; i < GPIO_UP_LO; i++) begin
			avail[i] = 1'b0;
		end
		for (int i = GPIO_UP_LO; i <= GPIO_UP_HI; i++) begin
			avail[i] = !pci_sel_q;
		end
	end
	wire logic [GPIO_W-1:0] g_on = gpio_en_q & avail;
	wire logic [GPIO_W-1:0] g_oe = g_on & gpio_dir_q;
	wire logic [GPIO_W-1:0] g_in = g_on & ~gpio_dir_q;

	// Pad drive selection
	logic [GPIO_W-1:0] gp_o_d, gp_oe_d;
	always_comb begin
		gp_o_d = gpio_out_q;
		gp_oe_d = g_oe;
		if (!gpio_en_q[GPIO1_BIT]) begin
			gp_o_d[GPIO1_BIT] = qclk_q;
			gp_oe_d[GPIO1_BIT] = 1'b1;
		end
		if (!gpio_en_q[GPIO2_BIT]) begin
			gp_o_d[GPIO2_BIT] = sclk_q;
			gp_oe_d[GPIO2_BIT] = 1'b1;
		end
		for (int i = GPIO_UP_LO; i <= GPIO_UP_HI; i++) begin
			if (pci_sel_q) begin
				gp_o_d[i] = pci_upper_o[i];
				gp_oe_d[i] = pci_upper_oe[i];
			end
		end
	end

	wire spf_drive_t hd_d = pci_sel_q ? pci_ad_drive
		: host_port_drive;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gpio_pad_o <= '0;
			gpio_pad_oe <= '0;
			host_port_data_pins_o <= '0;
			host_port_data_pins_oe <= '0;
			pci_only_pad_o <= '0;
			pci_only_pad_oe <= '0;
			pci_upper_i <= '0;
			host_port_data_in <= '0;
			pci_ad_in <= '0;
			pci_enabled <= 1'b0;
			host_port_enabled <= 1'b0;
		end else begin
			gpio_pad_o <= gp_o_d;
			gpio_pad_oe <= gp_oe_d;
			host_port_data_pins_o <= hd_d.o;
			host_port_data_pins_oe <= hd_d.oe;
			pci_only_pad_o <= pci_sel_q ? pci_only_o : '0;
			pci_only_pad_oe <= pci_sel_q ? pci_only_oe : '0;
			pci_upper_i <= pci_sel_q ? gin_s_q[GPIO_UP_HI:GPIO_UP_LO] : '0;
			host_port_data_in <= pci_sel_q ? '0 : hd_s_q;
			pci_ad_in <= pci_sel_q ? hd_s_q : '0;
			pci_enabled <= pci_sel_q;
			host_port_enabled <= !pci_sel_q;
		end
	end

	// Read channel
	logic [DATA_W-1:0] rd_d;
	logic rd_ok;
	always_comb begin
		rd_d = '0;
		rd_ok = 1'b1;
		unique case (s_axi_araddr)
			GPIO_EN_OFS: rd_d[GPIO_W-1:0] = gpio_en_q;
			GPIO_DIR_OFS: rd_d[GPIO_W-1:0] = gpio_dir_q;
			GPIO_OUT_OFS: rd_d[GPIO_W-1:0] = gpio_out_q;
			GPIO_IN_OFS: rd_d[GPIO_W-1:0] = gin_s_q & g_on;
			PIN_STAT_OFS: rd_d[0] = pci_sel_q;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Checks
	pci_sel_hold_a: assert property (@(posedge clk)
		!sys_rst && !$past(sys_rst) |-> $stable(pci_sel_q))
		else $error("PCI select changed outside reset");
	sel_output_a: assert property (@(posedge clk)
		!sys_rst && !$past(sys_rst) |-> pci_enabled == pci_sel_q
		&& host_port_enabled == !pci_sel_q)
		else $error("Owner outputs differ from latched select");
	pci_only_off_a: assert property (@(posedge clk)
		disable iff (sys_rst) !pci_sel_q |=> pci_only_pad_oe == '0)
		else $error("PCI-only pad driven while host port selected");
	host_owner_a: assert property (@(posedge clk)
		disable iff (sys_rst) !pci_sel_q
		|=> host_port_data_pins_oe == $past(host_port_drive.oe))
		else $error("Host port lost ownership");
	pci_owner_a: assert property (@(posedge clk)
		disable iff (sys_rst) pci_sel_q
		|=> host_port_data_pins_oe == $past(pci_ad_drive.oe))
		else $error("PCI lost ownership");
	single_owner_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		!$past(sys_rst) |-> host_port_enabled != pci_enabled)
		else $error("Shared pins owner not unique");
	quarter_clk_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		$rose(qclk_q) |-> ##2 $fell(qclk_q) ##2 $rose(qclk_q))
		else $error("Quarter-rate clock period wrong");
	quarter_pin_a: assert property (@(posedge clk)
		disable iff (sys_rst) !gpio_en_q[GPIO1_BIT]
		|=> gpio_pad_oe[GPIO1_BIT] && gpio_pad_o[GPIO1_BIT] == $past(qclk_q))
		else $error("Quarter-rate clock missing at its pin");
	sixth_clk_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		$rose(sclk_q) |-> ##3 $fell(sclk_q) ##3 $rose(sclk_q))
		else $error("Sixth-rate clock period wrong");
	sixth_pin_a: assert property (@(posedge clk)
		disable iff (sys_rst) !gpio_en_q[GPIO2_BIT]
		|=> gpio_pad_oe[GPIO2_BIT] && gpio_pad_o[GPIO2_BIT] == $past(sclk_q))
		else $error("Sixth-rate clock missing at its pin");
	upper_gate_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		pci_sel_q |-> (g_oe[GPIO_UP_HI:GPIO_UP_LO] == '0))
		else $error("Upper GPIO driven while PCI selected");
	gpio_dir_a: assert property (@(posedge clk)
		disable iff (sys_rst)
		g_in != '0 |=> (gpio_pad_oe & $past(g_in)) == '0)
		else $error("Input GPIO pad driven");
	gpio_drive_a: assert property (@(posedge clk)
		disable iff (sys_rst) g_oe != '0
		|=> (gpio_pad_oe & $past(g_oe)) == $past(g_oe)
		&& (gpio_pad_o & $past(g_oe)) == ($past(gpio_out_q) & $past(g_oe)))
		else $error("Output GPIO pad not driven from its register");
	sw_change_a: assert property (@(posedge clk)
		disable iff (sys_rst) wr_en && w_strb_q[1:0] == 2'h3
		|=> gpio_en_q == $past(w_low))
		else $error("Enable write not applied");
endmodule

// ---- verification/spf_board_model.sv ----
// Board side of the pads: device drive, board driver, else pull-down
`timescale 1ns/100ps
module spf_board_model #(
	parameter int W = 16
) (
	input wire logic [W-1:0] pad_o,
	input wire logic [W-1:0] pad_oe,
	input wire logic [W-1:0] ext_v,
	input wire logic [W-1:0] ext_en,
	output logic [W-1:0] pad_i
);
	// Released pads with no board driver fall to the pull-down level
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_v);
endmodule

// ---- verification/shared_pin_function_select_tb_top.sv ----
// Testbench for the shared pin function selector
`timescale 1ns/100ps
module shared_pin_function_select_tb_top;
	import spf_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pci_strap = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [GPIO_W-1:0] gp_i, gp_o, gp_oe, gx_v = '0, gx_en = '0;
	logic [HOST_W-1:0] hp_i, hp_o, hp_oe, hx_v = '0, hp_in, pci_in;
	spf_drive_t hdrv = '0, pdrv = '0;
	logic [GPIO_UP_HI:GPIO_UP_LO] up_o = '0, up_oe = '0, up_i;
	logic [PCI_ONLY_W-1:0] po_o = '0, po_oe = '0, pp_o, pp_oe;
	logic pci_en, hp_en;
	logic [33:0] exp_q[$];
	int miscompares = 0, comparisons = 0, seed = 94;
	logic [15:0] d, o, m, e;

	always #20 clk = ~clk;

	spf_pin_mux i_dut (.clk(clk), .sys_rst(sys_rst), .pci_strap(pci_strap),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .gpio_pad_i(gp_i), .gpio_pad_o(gp_o),
		.gpio_pad_oe(gp_oe), .host_port_drive(hdrv), .pci_ad_drive(pdrv),
		.host_port_data_pins_i(hp_i), .host_port_data_pins_o(hp_o),
		.host_port_data_pins_oe(hp_oe), .pci_upper_o(up_o),
		.pci_upper_oe(up_oe), .pci_upper_i(up_i), .pci_only_o(po_o),
		.pci_only_oe(po_oe), .pci_only_pad_o(pp_o), .pci_only_pad_oe(pp_oe),
		.host_port_data_in(hp_in), .pci_ad_in(pci_in),
		.pci_enabled(pci_en), .host_port_enabled(hp_en));
	spf_board_model #(.W(16)) i_gp (.pad_o(gp_o), .pad_oe(gp_oe),
		.ext_v(gx_v), .ext_en(gx_en), .pad_i(gp_i));
	spf_board_model #(.W(32)) i_hp (.pad_o(hp_o), .pad_oe(hp_oe),
		.ext_v(hx_v), .ext_en(32'hffffffff), .pad_i(hp_i));

	task chk(input logic [33:0] seen, input logic [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [33:0] x);
		exp_q.push_back(x);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	// Scoreboard: each bus answer against the oldest expectation
	always @(posedge clk) begin
		if (bvalid && bready) chk({bresp, 32'h0}, exp_q.pop_front());
		if (rvalid && rready) chk({rresp, rdata}, exp_q.pop_front());
	end

	task run_len(input int i, input logic v, input int n);
		int k;
		k = 0;
		while (gp_o[i] === v) @(posedge clk);
		while (gp_o[i] !== v) @(posedge clk);
		while (gp_o[i] === v) begin
			k++;
			@(posedge clk);
		end
		chk(34'(k), 34'(n));
	endtask

	task pass(input logic s);
		sys_rst <= 1'b1;
		pci_strap <= s;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		pci_strap <= ~s;
		hdrv <= {$random(seed), $random(seed)};
		pdrv <= {$random(seed), $random(seed)};
		up_o <= 7'($random(seed));
		up_oe <= 7'($random(seed));
		po_o <= 5'($random(seed));
		po_oe <= 5'($random(seed));
		hx_v <= $random(seed);
		m = s ? 16'h0006 : 16'hfe06;
		repeat (5) @(posedge clk);
		chk({pci_en, hp_en}, s ? 2'b10 : 2'b01);
		chk(hp_oe, s ? pdrv.oe : hdrv.oe);
		chk(hp_o & hp_oe, s ? pdrv.o & pdrv.oe : hdrv.o & hdrv.oe);
		chk(s ? pci_in : hp_in, hp_i);
		chk(s ? hp_in : pci_in, 32'h0);
		chk({pp_oe, pp_o & pp_oe}, s ? {po_oe, po_o & po_oe} : 10'h0);
		rd(PIN_STAT_OFS, {RESP_OKAY, 31'h0, s});
		chk(gp_oe[2:1], 2'b11);
		run_len(1, 1'b1, 2);
		run_len(1, 1'b0, 2);
		run_len(2, 1'b1, 3);
		run_len(2, 1'b0, 3);
		d = 16'($random(seed));
		o = 16'($random(seed));
		gx_v <= 16'($random(seed));
		gx_en <= 16'($random(seed));
		wr(GPIO_EN_OFS, 32'hffff, RESP_OKAY);
		wr(GPIO_DIR_OFS, {16'h0, d}, RESP_OKAY);
		wr(GPIO_OUT_OFS, {16'h0, o}, RESP_OKAY);
		repeat (2) @(posedge clk);
		e = (d & m) | (s ? {up_oe, 9'h0} : 16'h0);
		chk(gp_oe, e);
		chk(gp_o & d & m, o & d & m);
		repeat (3) @(posedge clk);
		e = ((o & d) | (gx_v & gx_en & ~d)) & m;
		rd(GPIO_IN_OFS, {RESP_OKAY, 16'h0, e});
		chk(up_i, s ? gp_i[15:9] : 7'h0);
		rd(GPIO_DIR_OFS, {RESP_OKAY, 16'h0, d});
		wr(8'h40, 32'h1, RESP_SLVERR);
		wr(GPIO_EN_OFS, 32'h0, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk(gp_oe, 16'h0006 | (s ? {up_oe, 9'h0} : 16'h0));
	endtask

	task print_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		pass(1'b0);
		pass(1'b1);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
endmodule
